// ---- sim/lbcs_link_monitor.sv ----
// link checker for the burst configuration sequencer
`timescale 1ns/1ps
`include "lbcs_defs.svh"
module lbcs_link_monitor (
    input wire logic clk_sys_in, // sdram clock
    input wire logic rst_in, // sync reset
    input lbcs_pkg::lbcs_cmd_e cmd, // link command
    input wire logic [7:0] rdata, // mode read data
    input wire logic rdata_valid, // read data pulse
    input wire logic data_strobe, // read strobe
    input wire logic [9:0] beat_col, // beat column
    input wire logic beat_valid, // beat pulse
    input wire logic burst_done, // end of burst
    input wire logic precharge_start // precharge pulse
);
    typedef struct packed {logic [4:0] run; logic [3:0] gap;} lbcs_mon_s;
    lbcs_mon_s st_q, st_d;
    always_comb
    begin
        st_d = st_q;
        st_d.run = beat_valid ? st_q.run + 5'h1 : 5'h0;
        st_d.gap = burst_done ? 4'h0 : st_q.gap + {3'h0, st_q.gap != 4'hF};
    end
    always_ff @(posedge clk_sys_in)
    begin
        st_q <= rst_in ? '0 : st_d;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    a_mrr_data_time: assert property (cmd == lbcs_pkg::LBCS_CMD_MRR |-> ##3 rdata_valid)
        else $error("mode read data late or early");
    a_mrr_undef_data: assert property (rdata_valid |-> rdata == `LBCS_UNDEF_DATA)
        else $error("mode read data not the undefined pattern");
    a_mrr_strobe: assert property (cmd == lbcs_pkg::LBCS_CMD_MRR |-> ##[1:3] $changed(data_strobe))
        else $error("strobe did not toggle on mode read");
    a_burst_start: assert property (cmd == lbcs_pkg::LBCS_CMD_BURST |=> beat_valid)
        else $error("burst did not start one cycle after command");
    a_first_even: assert property (beat_valid && !$past(beat_valid) |-> !beat_col[0])
        else $error("first beat column odd");
    a_beat_pairs: assert property (beat_valid && $past(beat_valid) |-> beat_col[0] != $past(beat_col[0]))
        else $error("beat columns not in even odd pairs");
    a_done_length: assert property (burst_done |-> !beat_valid && st_q.run inside {5'h4, 5'h8, 5'h10})
        else $error("burst length not 4, 8 or 16");
    a_precharge_gap: assert property (precharge_start |-> st_q.gap inside {[4'h2:4'h7]})
        else $error("precharge outside recovery window");
endmodule : lbcs_link_monitor

// ---- sim/lpddr2_burst_config_sequencer_tb.sv ----
// self-checking bench joining controller and sdram ends over the link
`timescale 1ns/1ps
`include "lbcs_defs.svh"
module lpddr2_burst_config_sequencer_tb;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [7:0] shadow;
    logic [3:0] wr_cyc;
    int err_count = 0, n_checks = 0, since = 0;
    logic [64:0] apb_q[$];
    logic [9:0] beat_q[$];
    logic [3:0] pre_q[$];
    lbcs_link_if link ();
    lbcs_ctrl lbcs_ctrl_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.ctrl));
    lbcs_sdram lbcs_sdram_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link.sdram),
        .cfg_shadow_out(shadow), .wr_cycles_out(wr_cyc));
    lbcs_link_monitor lbcs_link_monitor_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .cmd(link.cmd), .rdata(link.rdata), .rdata_valid(link.rdata_valid),
        .data_strobe(link.data_strobe), .beat_col(link.beat_col), .beat_valid(link.beat_valid),
        .burst_done(link.burst_done), .precharge_start(link.precharge_start));
    initial
    begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // exp holds {error, data mask, data}
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [64:0] exp, output logic [31:0] rd);
        int n;
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        apb_q.push_back(exp);
        @(posedge clk_sys_in);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_sys_in);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            err_count++;
            end_of_test();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle();
        logic [31:0] rd;
        int n;
        for (n = 0; n < 40; n++)
        begin
            apb(1'b0, `LBCS_REG_STAT, 32'h0, 65'h0, rd);
            if (rd[0] === 1'b0)
                break;
        end
        if (n == 40)
        begin
            err_count++;
            end_of_test();
        end
    endtask : wait_idle
    // ----------------------------------------
    // result watcher: compares against oldest note
    // ----------------------------------------
    always @(posedge clk_sys_in)
    begin
        logic [64:0] e;
        since = link.burst_done ? 0 : since + 1;
        if (pready === 1'b1)
        begin
            e = apb_q.size() ? apb_q.pop_front() : {1'b1, 64'h0};
            chk({31'h0, pslverr}, {31'h0, e[64]});
            chk(prdata & e[63:32], e[31:0] & e[63:32]);
        end
        if (link.beat_valid === 1'b1)
            chk({22'h0, link.beat_col}, beat_q.size() ? {22'h0, beat_q.pop_front()} : '1);
        if (link.precharge_start === 1'b1)
            chk(since, pre_q.size() ? {28'h0, pre_q.pop_front()} : '1);
    end
    initial
    begin
        logic [31:0] rd;
        logic [7:0] cur;
        logic [9:0] col, s, m, lo;
        logic [1:0] wa;
        logic ok, nw;
        int n;
        void'($urandom(32'h46515825));
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        apb(1'b0, `LBCS_REG_CFG, 32'h0, {1'b0, 32'hFF, 32'h22}, rd);
        chk({28'h0, wr_cyc}, 32'h3);
        apb(1'b0, 12'h020, 32'h0, {1'b1, 64'h0}, rd);
        $display("test reset done");
        cur = 8'h22;
        for (int c = 0; c < 256; c++)
        begin
            ok = c[2:0] inside {[3'h2:3'h4]} && c[7:5] inside {[3'h1:3'h6]};
            ok = ok && !(c[4] && c[2:0] != 3'h2) && !(c[3] && c[2:0] == 3'h4);
            apb(1'b1, `LBCS_REG_CFG, c, {!ok, 64'h0}, rd);
            cur = ok ? c[7:0] : cur;
            apb(1'b0, `LBCS_REG_CFG, 32'h0, {1'b0, 32'hFF, 24'h0, cur}, rd);
            if (ok)
            begin
                nw = cur[4];
                col = nw ? (c[5] ? 10'h1FE : 10'($urandom_range(0, 32'h1FC))) : 10'($urandom);
                wa = 2'($urandom);
                ok = !(nw && col > 10'h1FC);
                n = 4 << (cur[2:0] - 3'h2);
                s = {col[9:1], 1'b0};
                m = 10'(n - 1);
                for (int k = 0; k < n && ok; k++)
                begin
                    lo = cur[3] ? (s ^ 10'(k)) : (s + 10'(k));
                    beat_q.push_back(nw ? s + 10'(k) : ((s & ~m) | (lo & m)));
                end
                if (ok && wa == 2'h3)
                    pre_q.push_back({1'b0, cur[7:5]} + 4'h2);
                apb(1'b1, `LBCS_REG_BURST, {14'h0, wa, 6'h0, col}, {!ok, 64'h0}, rd);
                wait_idle();
                repeat (10) @(posedge clk_sys_in);
                chk({24'h0, shadow}, {24'h0, cur});
                chk({28'h0, wr_cyc}, {29'h0, cur[7:5]} + 32'h2);
            end
        end
        $display("test config sweep done");
        apb(1'b1, `LBCS_REG_CTRL, 32'h01, 65'h0, rd);
        apb(1'b0, `LBCS_REG_CTRL, 32'h0, {1'b0, 32'hFF, 32'h01}, rd);
        apb(1'b0, `LBCS_REG_RDATA, 32'h0, {1'b0, 32'hFF, 24'h0, `LBCS_UNDEF_DATA}, rd);
        $display("test mode read done");
        repeat (4) @(posedge clk_sys_in);
        chk(apb_q.size() + beat_q.size() + pre_q.size(), 32'h0);
        end_of_test();
    end
endmodule : lpddr2_burst_config_sequencer_tb

// ---- src/lbcs_col_gen.sv ----
// column address of one burst beat from start column and configuration
`timescale 1ns/1ps
`include "lbcs_defs.svh"
module lbcs_col_gen #(
    parameter int COL_W = 10
) (
    input wire logic [COL_W-1:0] start_in, // burst start column
    input wire logic [3:0] beat_in,        // beat index
    input wire logic [2:0] beats_sel_in,   // burst length code
    input wire logic order_in,             // 1 = interleaved
    input wire logic nowrap_in,            // 1 = no wrap
    output logic [COL_W-1:0] col_out       // column of this beat
);
    logic [3:0] mask;
    logic [3:0] base;
    logic [3:0] lo;
    always_comb
    begin
        unique case (beats_sel_in)
            `LBCS_BEATS_8: mask = 4'h7;
            `LBCS_BEATS_16: mask = 4'hF;
            default: mask = 4'h3;
        endcase
        base = {start_in[3:1], 1'b0};
        if (order_in)
            lo = base ^ beat_in;
        else
            lo = base + beat_in;
        if (nowrap_in)
            col_out = {start_in[COL_W-1:1], 1'b0} + COL_W'(beat_in);
        else
            col_out = {start_in[COL_W-1:4], (base & ~mask) | (lo & mask)};
    end
endmodule : lbcs_col_gen

// ---- src/lbcs_ctrl.sv ----
// controller end: apb registers drive mode writes, reads and bursts
`timescale 1ns/1ps
`include "lbcs_defs.svh"
module lbcs_ctrl (
    input wire logic clk_sys_in,          // system clock
    input wire logic rst_in,              // synchronous reset, high
    input wire logic psel,                // apb select
    input wire logic penable,             // apb enable
    input wire logic pwrite,              // apb direction
    input wire logic [11:0] paddr,        // apb address
    input wire logic [31:0] pwdata,       // apb write data
    output logic [31:0] prdata,           // apb read data
    output logic pready,                  // apb ready
    output logic pslverr,                 // apb error
    lbcs_link_if.ctrl link                // command/address link
);
    typedef struct packed {
        lbcs_pkg::lbcs_cmd_e cmd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bw;
        logic close;
        logic [9:0] col;
        logic [7:0] cfg;
        logic busy;
        logic [7:0] rd;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } lbcs_ct_s;
    lbcs_ct_s s_q;
    lbcs_ct_s s_d;
    logic acc;
    logic [2:0] wr_code;
    always_comb
    begin
        s_d = s_q;
        s_d.cmd = lbcs_pkg::LBCS_CMD_NONE;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        acc = psel & penable & ~s_q.pready;
        wr_code = pwdata[7:5];
        if (link.rdata_valid)
            s_d.rd = link.rdata;
        if (link.burst_done)
            s_d.busy = 1'b0;
        if (acc)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = `LBCS_ERR_DATA;
            if (pwrite)
            begin
                unique case (paddr)
                    `LBCS_REG_CFG:
                    begin
                        if (pwdata[2:0] < `LBCS_BEATS_4 || pwdata[2:0] > `LBCS_BEATS_16 ||
                            wr_code < `LBCS_WR_MIN || wr_code > `LBCS_WR_MAX ||
                            (pwdata[4] && pwdata[2:0] != `LBCS_BEATS_4) ||
                            (pwdata[3] && pwdata[2:0] == `LBCS_BEATS_16))
                            s_d.pslverr = 1'b1;
                        else
                        begin
                            s_d.cmd = lbcs_pkg::LBCS_CMD_MRW;
                            s_d.addr = `LBCS_CFG_ADDR;
                            s_d.wdata = {pwdata[7:5], pwdata[4:0]};
                            s_d.cfg = pwdata[7:0];
                        end
                    end
                    `LBCS_REG_BURST:
                    begin
                        // no-wrap across last page columns refused
                        if (s_q.cfg[4] && pwdata[9:0] > 10'h1FC)
                            s_d.pslverr = 1'b1;
                        else
                        begin
                            s_d.cmd = lbcs_pkg::LBCS_CMD_BURST;
                            s_d.col = pwdata[9:0];
                            s_d.bw = pwdata[16];
                            s_d.close = pwdata[17];
                            s_d.busy = 1'b1;
                        end
                    end
                    `LBCS_REG_CTRL:
                    begin
                        s_d.cmd = lbcs_pkg::LBCS_CMD_MRR;
                        s_d.addr = pwdata[7:0];
                    end
                    default: s_d.pslverr = 1'b1;
                endcase
            end
            else
            begin
                unique case (paddr)
                    `LBCS_REG_CFG: s_d.prdata = {24'h0, s_q.cfg};
                    `LBCS_REG_STAT: s_d.prdata = {31'h0, s_q.busy};
                    `LBCS_REG_RDATA: s_d.prdata = {24'h0, s_q.rd};
                    `LBCS_REG_CTRL: s_d.prdata = {24'h0, s_q.addr};
                    default: s_d.pslverr = 1'b1;
                endcase
            end
        end
    end
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_q <= '0;
            s_q.cmd <= lbcs_pkg::LBCS_CMD_NONE;
            s_q.cfg <= `LBCS_CFG_RESET;
        end
        else
            s_q <= s_d;
    end
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign link.cmd = s_q.cmd;
    assign link.addr = s_q.addr;
    assign link.wdata = s_q.wdata;
    assign link.burst_write = s_q.bw;
    assign link.auto_close_row = s_q.close;
    assign link.start_col = s_q.col;
endmodule : lbcs_ctrl

// ---- src/lbcs_defs.svh ----
// constants of the burst configuration register and column sequencing
`ifndef LBCS_DEFS_SVH
`define LBCS_DEFS_SVH
`define LBCS_ADDR_W 8
`define LBCS_DATA_W 8
`define LBCS_COL_W 10
`define LBCS_CFG_ADDR 8'h01
`define LBCS_BEATS_LSB 0
`define LBCS_BEATS_MSB 2
`define LBCS_ORDER_BIT 3
`define LBCS_WRAP_BIT 4
`define LBCS_WR_LSB 5
`define LBCS_WR_MSB 7
`define LBCS_BEATS_4 3'h2
`define LBCS_BEATS_8 3'h3
`define LBCS_BEATS_16 3'h4
`define LBCS_WR_MIN 3'h1
`define LBCS_WR_MAX 3'h6
`define LBCS_WR_OFS 4'h2
`define LBCS_WR_CYC_RESET 4'h3
`define LBCS_CFG_RESET 8'h22
`define LBCS_UNDEF_DATA 8'hA5
`define LBCS_RD_LAT 2'h2
`define LBCS_WRT_REC_NS 15
`define LBCS_CLK_NS 50
`define LBCS_WRT_REC_CYC (((`LBCS_WRT_REC_NS + `LBCS_CLK_NS - 1) / `LBCS_CLK_NS) + 2)
`define LBCS_REG_CTRL 12'h000
`define LBCS_REG_CFG 12'h004
`define LBCS_REG_BURST 12'h008
`define LBCS_REG_STAT 12'h00C
`define LBCS_REG_RDATA 12'h010
`define LBCS_ERR_DATA 32'h0000_0000
`endif

// ---- src/lbcs_link_if.sv ----
// command/address link between controller and sdram burst logic
`timescale 1ns/1ps
interface lbcs_link_if;
    lbcs_pkg::lbcs_cmd_e cmd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic burst_write;
    logic auto_close_row;
    logic [9:0] start_col;
    logic [7:0] rdata;
    logic rdata_valid;
    logic data_strobe;
    logic [9:0] beat_col;
    logic beat_valid;
    logic burst_done;
    logic precharge_start;
    modport sdram (input cmd, addr, wdata, burst_write, auto_close_row, start_col,
        output rdata, rdata_valid, data_strobe, beat_col, beat_valid, burst_done,
        precharge_start);
    modport ctrl (output cmd, addr, wdata, burst_write, auto_close_row, start_col,
        input rdata, rdata_valid, data_strobe, beat_col, beat_valid, burst_done,
        precharge_start);
endinterface : lbcs_link_if

// ---- src/lbcs_pkg.sv ----
// types shared by both ends of the burst configuration link
package lbcs_pkg;
    typedef enum logic [1:0] {LBCS_CMD_NONE, LBCS_CMD_MRW, LBCS_CMD_MRR, LBCS_CMD_BURST} lbcs_cmd_e;
endpackage : lbcs_pkg

// ---- src/lbcs_sdram.sv ----
// sdram end: burst configuration register and beat column sequencer
//
// Overview of operation
// - write-only burst config at address 01
// - bit 4 no-wrap, only legal with 4
// - auto-close write precharges after recovery cycles
// - controller rounds recovery time up to cycles; here the written code passes unchanged, cycles = code + 2
// - lowest column bit forced to zero
// - 4-beat wrap orders column bits 1:0
// - 8-beat sequential mod 8, interleaved by xor
// - 16-beat sequential only, mod 16
// - no-wrap runs y to y+3 linearly
// - controller avoids no-wrap over page end
// - register access only by mrw and mrr
// - mrr of write-only returns junk, strobe toggles
`timescale 1ns/1ps
`include "lbcs_defs.svh"
module lbcs_sdram (
    input wire logic clk_sys_in,          // sdram clock
    input wire logic rst_in,              // synchronous reset, high
    lbcs_link_if.sdram link,              // command/address link
    output logic [7:0] cfg_shadow_out,    // captured configuration
    output logic [3:0] wr_cycles_out      // decoded recovery cycles
);
    // ---------------------------------------------------------
    // state record
    // ---------------------------------------------------------
    // the whole end lives in one registered record
    typedef enum logic [1:0] {LBCS_S_IDLE, LBCS_S_BURST, LBCS_S_REC} lbcs_sd_state_e;
    typedef struct packed {
        lbcs_sd_state_e st;
        logic [7:0] cfg;
        logic [9:0] start;
        logic [3:0] beat;
        logic [3:0] rec;
        logic close;
        logic [1:0] rd_cnt;
        logic [7:0] rdata;
        logic rvalid;
        logic strobe;
        logic bvalid;
        logic [9:0] bcol;
        logic done;
        logic pre;
        logic [2:0] beats;
        logic order;
        logic nowrap;
        logic [3:0] wrc;
    } lbcs_sd_s;
    lbcs_sd_s s_q;
    lbcs_sd_s s_d;
    logic [9:0] col;
    logic [3:0] last;
    logic [9:0] gen_start;
    logic [3:0] gen_beat;
    logic [2:0] gen_beats_sel;
    logic gen_order;
    logic gen_nowrap;
    // ---------------------------------------------------------
    // beat column generator
    // ---------------------------------------------------------
    // fed from registered state and link.start_col only, so no loop through the next-state record
    always_comb
    begin
        if (s_q.st == LBCS_S_IDLE)
        begin
            gen_start = link.start_col;
            gen_beat = 4'h0;
            gen_beats_sel = s_q.cfg[`LBCS_BEATS_MSB:`LBCS_BEATS_LSB];
            gen_order = s_q.cfg[`LBCS_ORDER_BIT];
            gen_nowrap = s_q.cfg[`LBCS_WRAP_BIT];
        end
        else
        begin
            gen_start = s_q.start;
            gen_beat = s_q.beat + 4'h1;
            gen_beats_sel = s_q.beats;
            gen_order = s_q.order;
            gen_nowrap = s_q.nowrap;
        end
    end
    lbcs_col_gen #(.COL_W(10)) u_col (
        .start_in(gen_start),
        .beat_in(gen_beat),
        .beats_sel_in(gen_beats_sel),
        .order_in(gen_order),
        .nowrap_in(gen_nowrap),
        .col_out(col)
    );
    // ---------------------------------------------------------
    // next state
    // ---------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.pre = 1'b0;
        s_d.rvalid = 1'b0;
        s_d.bvalid = 1'b0;
        unique case (s_q.beats)
            `LBCS_BEATS_8: last = 4'h7;
            `LBCS_BEATS_16: last = 4'hF;
            default: last = 4'h3;
        endcase
        // ---------------------------------------------------------
        // register commands
        // ---------------------------------------------------------
        if (link.cmd == lbcs_pkg::LBCS_CMD_MRW && link.addr == `LBCS_CFG_ADDR)
            s_d.cfg = link.wdata;
        s_d.wrc = 4'(s_d.cfg[`LBCS_WR_MSB:`LBCS_WR_LSB]) + `LBCS_WR_OFS;
        // no mode register is readable here: every read returns the fill pattern
        if (link.cmd == lbcs_pkg::LBCS_CMD_MRR && s_q.rd_cnt == 2'h0)
            s_d.rd_cnt = `LBCS_RD_LAT;
        if (s_q.rd_cnt != 2'h0)
        begin
            s_d.rd_cnt = s_q.rd_cnt - 2'h1;
            s_d.strobe = ~s_q.strobe;
            if (s_q.rd_cnt == 2'h1)
            begin
                s_d.rvalid = 1'b1;
                s_d.rdata = `LBCS_UNDEF_DATA;
            end
        end
        // ---------------------------------------------------------
        // burst sequencing
        // ---------------------------------------------------------
        unique case (s_q.st)
            LBCS_S_IDLE:
            begin
                if (link.cmd == lbcs_pkg::LBCS_CMD_BURST)
                begin
                    s_d.st = LBCS_S_BURST;
                    s_d.start = link.start_col;
                    s_d.beat = 4'h0;
                    s_d.close = link.burst_write & link.auto_close_row;
                    // recovery count latched here so a later write cannot alter it
                    s_d.rec = s_q.wrc;
                    s_d.beats = s_q.cfg[`LBCS_BEATS_MSB:`LBCS_BEATS_LSB];
                    s_d.order = s_q.cfg[`LBCS_ORDER_BIT];
                    s_d.nowrap = s_q.cfg[`LBCS_WRAP_BIT];
                    s_d.bvalid = 1'b1;
                    s_d.bcol = col;
                end
            end
            LBCS_S_BURST:
            begin
                if (s_q.beat == last)
                begin
                    s_d.done = 1'b1;
                    s_d.st = s_q.close ? LBCS_S_REC : LBCS_S_IDLE;
                end
                else
                begin
                    s_d.beat = s_q.beat + 4'h1;
                    s_d.bvalid = 1'b1;
                    s_d.bcol = col;
                end
            end
            LBCS_S_REC:
            begin
                s_d.rec = s_q.rec - 4'h1;
                if (s_q.rec == 4'h1)
                begin
                    s_d.pre = 1'b1;
                    s_d.st = LBCS_S_IDLE;
                end
            end
            default: s_d.st = LBCS_S_IDLE;
        endcase
    end
    // ---------------------------------------------------------
    // state register
    // ---------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_q <= '0;
            s_q.st <= LBCS_S_IDLE;
            s_q.cfg <= `LBCS_CFG_RESET;
            s_q.beats <= `LBCS_BEATS_4;
            s_q.wrc <= `LBCS_WR_CYC_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    // ---------------------------------------------------------
    // outputs, all straight from the record
    // ---------------------------------------------------------
    assign link.rdata = s_q.rdata;
    assign link.rdata_valid = s_q.rvalid;
    assign link.data_strobe = s_q.strobe;
    assign link.beat_col = s_q.bcol;
    assign link.beat_valid = s_q.bvalid;
    assign link.burst_done = s_q.done;
    assign link.precharge_start = s_q.pre;
    assign cfg_shadow_out = s_q.cfg;
    assign wr_cycles_out = s_q.wrc;
endmodule : lbcs_sdram
